//--- src/smsms_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the stop-mode supply sequencer
// ----------------------------------------------------------------
package smsms_pkg;

  // System clock period
  localparam int CLK_PERIOD_NS       = 50;

  // Supply warning qualifying time, least time rounds up
  localparam int WARN_QUAL_NS        = 10000;
  localparam int WARN_QUAL_CYC       = (WARN_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUAL_W              = 8;

  // Crystal settle time, least time rounds up
  localparam int XTAL_SETTLE_US      = 2000;
  localparam int XTAL_SETTLE_CYC_DEF = (XTAL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_W               = 17;

  // Pin or watchdog reset release delay, well under 20 cycles
  localparam int EXT_REL_CYC         = 4;

  // Periodic check: ring ticks before decision, shift base of interval
  localparam int CHECK_LAST_TICK     = 2;
  localparam int PER_BASE_SHIFT      = 10;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_WAKE   = 8'h0C;
  localparam logic [7:0] ADDR_STATE  = 8'h10;

  // Control register layout and reset value
  localparam int         CTRL_W      = 3;
  localparam int         CTRL_MONOFF = 0;
  localparam int         CTRL_SEL_LO = 1;
  localparam logic [2:0] CTRL_RST    = 3'h1;

  // Status and mask layout
  localparam int         STAT_W      = 4;
  localparam int         ST_WARN     = 0;
  localparam int         ST_WAKE     = 1;
  localparam int         ST_PFRST    = 2;
  localparam int         ST_POR      = 3;
  localparam logic [3:0] STAT_RST    = 4'h0;
  localparam logic [3:0] MASK_RST    = 4'h0;
  localparam logic [15:0] WAKE_RST   = 16'h0000;

  // Start addresses handed to the core on release
  localparam logic [15:0] ROM_RESUME_ADDR   = 16'h8000;
  localparam logic [15:0] NORMAL_START_ADDR = 16'h0000;

  // Synchroniser bit positions
  localparam int SY_WARN = 0;
  localparam int SY_RST  = 1;
  localparam int SY_POR  = 2;
  localparam int SY_EXT  = 3;
  localparam int SY_IRQ  = 4;
  localparam int SY_RING = 5;
  localparam int SY_W    = 6;

  // Sync value after reset: below power-on only, reset pin released, so boot waits for real levels
  localparam logic [SY_W-1:0] SYNC_RST = 6'h0C;

  // Sequencer states
  typedef enum logic [3:0] {
    S_POR_HOLD,
    S_BOOT_WARM,
    S_RUN,
    S_STOP,
    S_WAKE_XTAL,
    S_PF_RESET,
    S_PF_CHECK,
    S_PF_XTAL,
    S_EXT_HOLD,
    S_EXT_REL
  } smsms_state_e;

endpackage : smsms_pkg

//--- src/smsms_top.sv
`timescale 1ns/10ps
// How it works
// [R1] Reset holds pins floating, pullups off
// [R2] Stop halts core; wakes on IRQ, warning, reset
// [R3] Ring-clocked wake timer, 125us steps
// [R4] Monitor always on outside stop, POR hold and periodic fail reset
// [R5] Monitor-off-in-stop bit resets to one
// [R6] Monitor off: no warning, no reset
// [R7] Power-on reset still acts in stop
// [R8] Monitor on before stop exit; flag, reset
// [R9] Fail reset: continuous or 2^11..2^13 checks
// [R10] Check two ticks, extend one if good
// [R11] Good third tick: warm crystal, start 8000h
// [R12] Fail reset: regulator, crystal off
// [R13] Pin/watchdog reset keeps everything running
// [R14] Pin/watchdog release under 20 cycles
// [R15] Qualified warning sets flag, keeps running
// [R16] Short dips are ignored
// [R17] Warning in stop: warm crystal, then exit
// [R18] Below power-on level: hold reset
// [R19] Ring counter times checks and wake
module smsms_top
  import smsms_pkg::*;
#(
  parameter int XTAL_SETTLE_CYC = XTAL_SETTLE_CYC_DEF
)(
  input  wire logic        sys_clk,         // System clock, 20 MHz
  input  wire logic        rst_b,           // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped
  input  wire logic        belowWarnAsync,  // Supply below warning level
  input  wire logic        belowRstAsync,   // Supply below reset level
  input  wire logic        belowPorAsync,   // Supply below power-on level
  input  wire logic        extResetPin_b,   // Reset pin, active low
  input  wire logic        extIrqAsync,     // External I/O interrupt
  input  wire logic        ringOsc,         // 8 kHz ring oscillator
  input  wire logic        watchdogRst,     // Watchdog reset request
  input  wire logic        stopReq,         // Core asks for stop, pulse
  output logic             monitorEn,       // Supply monitor power
  output logic             regulatorEn,     // Internal regulator enable
  output logic             xtalEn,          // Crystal oscillator enable
  output logic             cpuReset,        // Core held in reset
  output logic             cpuHalt,         // Core halted in stop
  output logic             portsFloat,      // Pins hi-Z, pullups off
  output logic      [15:0] resumeAddr,      // Core start address
  output logic             irq              // Level interrupt
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SY_W-1:0]   syncA_ff;
  logic [SY_W-1:0]   syncB_ff;
  logic              ringPrev_ff;
  logic              belowWarn;
  logic              belowRst;
  logic              belowPor;
  logic              extSrc;
  logic              extIrq;
  logic              ringTick;

  // Two stages for every pin-side level
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA_ff    <= SYNC_RST;
      syncB_ff    <= SYNC_RST;
      ringPrev_ff <= 1'b0;
    end
    else
    begin
      syncA_ff    <= {ringOsc, extIrqAsync, extResetPin_b, belowPorAsync, belowRstAsync, belowWarnAsync};
      syncB_ff    <= syncA_ff;
      ringPrev_ff <= syncB_ff[SY_RING];
    end
  end

  // Reset value reads below power-on, so no boot before real levels arrive
  assign belowWarn = syncB_ff[SY_WARN];
  assign belowRst  = syncB_ff[SY_RST];
  assign belowPor  = syncB_ff[SY_POR];
  assign extSrc    = !syncB_ff[SY_EXT] || watchdogRst;
  assign extIrq    = syncB_ff[SY_IRQ];
  assign ringTick  = syncB_ff[SY_RING] && !ringPrev_ff;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  smsms_state_e         state_ff;
  smsms_state_e         nxtState;
  logic [CTRL_W-1:0]    ctrl_ff;
  logic [STAT_W-1:0]    status_ff;
  logic [STAT_W-1:0]    mask_ff;
  logic [15:0]          wakeIntv_ff;
  logic [15:0]          ringCnt_ff;
  logic [CYC_W-1:0]     cycCnt_ff;
  logic [QUAL_W-1:0]    warnCnt_ff;
  logic [QUAL_W-1:0]    rstCnt_ff;
  logic [15:0]          resumeAddr_ff;
  logic [31:0]          prdata_ff;

  // Saturating qualification counter step
  function automatic logic [QUAL_W-1:0] qualStep(input logic cond, input logic [QUAL_W-1:0] cnt);
    qualStep = !cond ? '0 : (cnt == QUAL_W'(WARN_QUAL_CYC)) ? cnt : cnt + 1'b1;
  endfunction : qualStep

  // ----------------------------------------------------------------
  // State decode
  // ----------------------------------------------------------------
  logic monOffInStop;
  logic contMode;
  logic clocksOn;
  logic stateChg;
  logic xtalDone;
  logic extRelDone;
  logic [15:0] periodLast;

  assign monOffInStop = ctrl_ff[CTRL_MONOFF];
  assign contMode     = ctrl_ff[CTRL_SEL_LO +: 2] == 2'b00; // [R9]
  assign periodLast   = (16'h0001 << (4'(PER_BASE_SHIFT) + {2'b00, ctrl_ff[CTRL_SEL_LO +: 2]})) - 16'h0001; // [R9]
  assign stateChg     = nxtState != state_ff;
  assign xtalDone     = cycCnt_ff == CYC_W'(XTAL_SETTLE_CYC - 1);
  assign extRelDone   = cycCnt_ff == CYC_W'(EXT_REL_CYC - 1);

  // Monitor on everywhere but stop (bit), fail reset (periodic) and POR
  assign monitorEn = (state_ff == S_STOP)     ? !monOffInStop : // [R4] [R5] [R6]
                     (state_ff == S_PF_RESET) ? contMode :      // [R12]
                     (state_ff != S_POR_HOLD);                  // [R8] [R10] [R13]

  // Regulator and crystal only run where code runs or is about to
  assign clocksOn    = state_ff inside {S_RUN, S_BOOT_WARM, S_WAKE_XTAL, S_PF_XTAL, S_EXT_HOLD, S_EXT_REL}; // [R12] [R13]
  assign regulatorEn = clocksOn;
  assign xtalEn      = clocksOn;
  assign cpuReset    = state_ff inside {S_POR_HOLD, S_BOOT_WARM, S_PF_RESET, S_PF_CHECK, S_PF_XTAL,
                                        S_EXT_HOLD, S_EXT_REL};                                  // [R18]
  assign cpuHalt     = state_ff inside {S_STOP, S_WAKE_XTAL};                                    // [R2]
  assign portsFloat  = cpuReset;                                                                 // [R1]
  assign resumeAddr  = resumeAddr_ff;

  // ----------------------------------------------------------------
  // Supply qualification
  // ----------------------------------------------------------------
  logic warnCond;
  logic rstCond;
  logic warnHit;
  logic warnQual;
  logic rstQual;
  logic wakeHit;

  // Comparators only count while the monitor is powered
  assign warnCond = monitorEn && belowWarn && !belowRst; // [R6]
  assign rstCond  = monitorEn && belowRst;               // [R6]
  assign warnHit  = warnCond && warnCnt_ff == QUAL_W'(WARN_QUAL_CYC - 1);   // [R16]
  assign warnQual = warnCond && warnCnt_ff >= QUAL_W'(WARN_QUAL_CYC - 1);   // [R16]
  assign rstQual  = rstCond && rstCnt_ff >= QUAL_W'(WARN_QUAL_CYC - 1);     // [R16]
  assign wakeHit  = state_ff == S_STOP && ringTick && wakeIntv_ff != 16'h0000
                    && ringCnt_ff == wakeIntv_ff - 16'h0001;                // [R3] [R19]

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxtState = state_ff;
    case (state_ff)
      S_POR_HOLD:
        if (!belowPor)
          nxtState = S_BOOT_WARM;
      S_BOOT_WARM:
        if (xtalDone && !belowRst)
          nxtState = S_RUN;
      S_RUN:
        if (rstQual)
          nxtState = S_PF_RESET;
        else if (stopReq)
          nxtState = S_STOP; // [R2]
      S_STOP:
        if (rstQual)
          nxtState = S_PF_RESET; // [R2]
        else if (extIrq || wakeHit || warnQual)
          nxtState = S_WAKE_XTAL; // [R2] [R3] [R17]
      S_WAKE_XTAL:
        if (xtalDone)
          nxtState = belowRst ? S_PF_RESET : S_RUN; // [R8] [R17]
      S_PF_RESET:
        if (contMode || (ringTick && ringCnt_ff == periodLast))
          nxtState = S_PF_CHECK; // [R9] [R19]
      S_PF_CHECK:
        if (ringTick && !belowRst && ringCnt_ff == 16'(CHECK_LAST_TICK))
          nxtState = S_PF_XTAL; // [R10] [R11]
        else if (ringTick && belowRst && !contMode)
          nxtState = S_PF_RESET; // [R10]
      S_PF_XTAL:
        if (belowRst)
          nxtState = S_PF_RESET;
        else if (xtalDone)
          nxtState = S_RUN; // [R11]
      S_EXT_HOLD:
        if (!extSrc)
          nxtState = S_EXT_REL;
      S_EXT_REL:
        if (extSrc)
          nxtState = S_EXT_HOLD;
        else if (extRelDone)
          nxtState = S_RUN; // [R14]
      default:
        nxtState = S_POR_HOLD;
    endcase
    if (extSrc && state_ff inside {S_RUN, S_STOP, S_WAKE_XTAL})
      nxtState = S_EXT_HOLD; // [R13]
    if (belowPor)
      nxtState = S_POR_HOLD; // [R7] [R18]
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [15:0]      nxt_ringCnt;
  logic [CYC_W-1:0] nxt_cycCnt;

  // Ring count restarts on a failed check; it also times the wake-up
  assign nxt_ringCnt = (stateChg || (state_ff == S_PF_CHECK && ringTick && belowRst)) ? 16'h0000 :
                       ringTick ? ringCnt_ff + 16'h0001 : ringCnt_ff; // [R19]
  assign nxt_cycCnt  = stateChg ? '0 : (&cycCnt_ff) ? cycCnt_ff : cycCnt_ff + 1'b1;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff   <= S_POR_HOLD;
      ringCnt_ff <= 16'h0000;
      cycCnt_ff  <= '0;
      warnCnt_ff <= '0;
      rstCnt_ff  <= '0;
    end
    else
    begin
      state_ff   <= nxtState;
      ringCnt_ff <= nxt_ringCnt;
      cycCnt_ff  <= nxt_cycCnt;
      warnCnt_ff <= qualStep(warnCond, warnCnt_ff); // [R16]
      rstCnt_ff  <= qualStep(rstCond, rstCnt_ff);   // [R16]
    end
  end

  // ----------------------------------------------------------------
  // Start address on release
  // ----------------------------------------------------------------
  logic [15:0] nxt_resumeAddr;

  assign nxt_resumeAddr = (state_ff == S_PF_XTAL && nxtState == S_RUN) ? ROM_RESUME_ADDR : // [R11]
                          (state_ff inside {S_BOOT_WARM, S_EXT_REL} && nxtState == S_RUN) ? NORMAL_START_ADDR :
                          resumeAddr_ff;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      resumeAddr_ff <= NORMAL_START_ADDR;
    else
      resumeAddr_ff <= nxt_resumeAddr;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic              apbSetup;
  logic              apbAccess;
  logic              selCtrl;
  logic              selStatus;
  logic              selMask;
  logic              selWake;
  logic              selState;
  logic              mapped;
  logic [31:0]       rdMux;
  logic [STAT_W-1:0] statSet;
  logic [STAT_W-1:0] statClr;

  assign apbSetup  = psel && !penable;
  assign apbAccess = psel && penable;
  assign selCtrl   = paddr == ADDR_CTRL;
  assign selStatus = paddr == ADDR_STATUS;
  assign selMask   = paddr == ADDR_MASK;
  assign selWake   = paddr == ADDR_WAKE;
  assign selState  = paddr == ADDR_STATE;
  assign mapped    = selCtrl || selStatus || selMask || selWake || selState;
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && !mapped;
  assign prdata    = prdata_ff;

  // Read data is captured in setup so the access phase answers at once
  assign rdMux = selCtrl   ? {29'h0, ctrl_ff} :
                 selStatus ? {28'h0, status_ff} :
                 selMask   ? {28'h0, mask_ff} :
                 selWake   ? {16'h0, wakeIntv_ff} :
                 selState  ? {25'h0, belowPor, belowRst, belowWarn, 4'(state_ff)} : 32'h0;

  // Events into the sticky status; the exit check also flags a warning
  assign statSet[ST_WARN]  = (warnHit && state_ff inside {S_RUN, S_STOP})
                             || (state_ff == S_WAKE_XTAL && nxtState == S_RUN && belowWarn); // [R15] [R8]
  assign statSet[ST_WAKE]  = wakeHit;
  assign statSet[ST_PFRST] = nxtState == S_PF_RESET && !(state_ff inside {S_PF_RESET, S_PF_CHECK});
  assign statSet[ST_POR]   = nxtState == S_POR_HOLD && state_ff != S_POR_HOLD;

  // Only bits already shown to software are cleared, so late events stay
  assign statClr = (apbAccess && !pwrite && selStatus) ? prdata_ff[STAT_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff     <= CTRL_RST; // [R5]
      status_ff   <= STAT_RST;
      mask_ff     <= MASK_RST;
      wakeIntv_ff <= WAKE_RST;
      prdata_ff   <= 32'h0;
    end
    else
    begin
      if (apbAccess && pwrite && selCtrl)
        ctrl_ff <= pwdata[CTRL_W-1:0];
      if (apbAccess && pwrite && selMask)
        mask_ff <= pwdata[STAT_W-1:0];
      if (apbAccess && pwrite && selWake)
        wakeIntv_ff <= pwdata[15:0]; // [R3]
      if (apbSetup)
        prdata_ff <= rdMux;
      status_ff <= (status_ff & ~statClr) | statSet;
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(status_ff & mask_ff); // [R15]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_porHold;
    belowPor |=> state_ff == S_POR_HOLD ##0 cpuReset ##0 !monitorEn;
  endproperty
  a_porHold: assert property (p_porHold) else $error("power-on hold not entered"); // [R18]
  property p_porInStop;
    state_ff == S_STOP && belowPor |=> cpuReset;
  endproperty
  a_porInStop: assert property (p_porInStop) else $error("power-on reset missed in stop"); // [R7]
  property p_pinsFloat;
    state_ff != S_RUN && !cpuHalt |-> portsFloat;
  endproperty
  a_pinsFloat: assert property (p_pinsFloat) else $error("pins not floating in reset"); // [R1]
  property p_monRun;
    state_ff == S_RUN |-> monitorEn;
  endproperty
  a_monRun: assert property (p_monRun) else $error("monitor off while running"); // [R4]
  property p_monOffStop;
    state_ff == S_STOP && monOffInStop |-> !monitorEn && !warnHit && !rstQual;
  endproperty
  a_monOffStop: assert property (p_monOffStop) else $error("monitor active in stop"); // [R6]
  property p_failOff;
    state_ff == S_PF_RESET |-> !regulatorEn && !xtalEn && cpuReset;
  endproperty
  a_failOff: assert property (p_failOff) else $error("clocks on in fail reset"); // [R12]
  property p_extOn;
    state_ff inside {S_EXT_HOLD, S_EXT_REL} |-> monitorEn && regulatorEn && xtalEn;
  endproperty
  a_extOn: assert property (p_extOn) else $error("supplies off in pin reset"); // [R13]
  property p_extRelease;
    state_ff == S_EXT_HOLD && !extSrc && !belowPor ##1 (!extSrc && !belowPor)[*4] |=> !cpuReset;
  endproperty
  a_extRelease: assert property (p_extRelease) else $error("pin reset release late"); // [R14]
  property p_warnFlag;
    warnHit && state_ff == S_RUN && !belowPor && !extSrc |=> status_ff[ST_WARN] && !cpuReset;
  endproperty
  a_warnFlag: assert property (p_warnFlag) else $error("warning flag not set"); // [R15]
  property p_shortDip;
    state_ff == S_RUN && !rstQual && !belowPor && !extSrc |=> state_ff != S_PF_RESET;
  endproperty
  a_shortDip: assert property (p_shortDip) else $error("unqualified dip caused reset"); // [R16]
  property p_checkPass;
    state_ff == S_PF_CHECK && ringTick && !belowRst && ringCnt_ff == 16'h0002 && !belowPor
      |=> state_ff == S_PF_XTAL ##0 xtalEn;
  endproperty
  a_checkPass: assert property (p_checkPass) else $error("good check did not warm crystal"); // [R11]
  property p_wakeTimer;
    wakeHit && !belowPor && !extSrc && !rstQual |=> state_ff == S_WAKE_XTAL ##0 regulatorEn && monitorEn;
  endproperty
  a_wakeTimer: assert property (p_wakeTimer) else $error("wake timer did not end stop"); // [R3]
  property p_romStart;
    state_ff == S_PF_XTAL && nxtState == S_RUN |=> resumeAddr == ROM_RESUME_ADDR && !cpuReset;
  endproperty
  a_romStart: assert property (p_romStart) else $error("fail reset exit not at rom"); // [R11]
endmodule : smsms_top

//--- testbench/smsms_partner.sv
`timescale 1ns/10ps
// ------------------------------------------------
// Core and supply comparator model
// ------------------------------------------------
module smsms_partner #(
  parameter int RING_HALF = 1250
)(
  input  wire logic       sys_clk,   // System clock
  input  wire logic [1:0] supplyLvl, // 0 ok, 1 warn, 2 fail, 3 dead
  input  wire logic       stopCmd,   // Bench asks core to stop
  output logic            belowWarn, // Below warning level
  output logic            belowRst,  // Below reset level
  output logic            belowPor,  // Below power-on level
  output logic            ringOsc,   // 8 kHz ring clock
  output logic            stopReq    // One-cycle stop pulse
);
  int ringCnt;

  // Known levels from time zero
  initial
  begin
    ringCnt   = 0;
    ringOsc   = 1'h0;
    stopReq   = 1'h0;
    belowWarn = 1'h0;
    belowRst  = 1'h0;
    belowPor  = 1'h0;
  end

  // Levels nest: a deep sag trips every comparator above it
  always @(posedge sys_clk)
  begin
    ringCnt   <= (ringCnt == RING_HALF - 1) ? 0 : ringCnt + 1;
    ringOsc   <= (ringCnt == RING_HALF - 1) ? ~ringOsc : ringOsc;
    stopReq   <= stopCmd;
    belowWarn <= (supplyLvl != 2'h0);
    belowRst  <= supplyLvl[1];
    belowPor  <= (supplyLvl == 2'h3);
  end
endmodule : smsms_partner

//--- testbench/smsms_top_test.sv
`timescale 1ns/10ps
module smsms_top_test
  import smsms_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} smsms_row_s;
  // ------------------------------------------------
  // Register table: write if asked, then read back
  // ------------------------------------------------
  localparam smsms_row_s ROWS [0:7] = '{
    '{1'h0, ADDR_CTRL, 32'h0, 32'h1, 1'h0},
    '{1'h0, ADDR_STATUS, 32'h0, 32'h0, 1'h0},
    '{1'h0, ADDR_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h0, ADDR_WAKE, 32'h0, 32'h0, 1'h0},
    '{1'h0, ADDR_STATE, 32'h0, 32'h2, 1'h0},
    '{1'h1, ADDR_WAKE, 32'hFFFF1234, 32'h1234, 1'h0},
    '{1'h1, ADDR_STATUS, 32'hF, 32'h0, 1'h0},
    '{1'h1, 8'h14, 32'h5, 32'h0, 1'h1}};
  logic        sys_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        extResetPin_b = 1'h1, extIrqAsync = 1'h0, watchdogRst = 1'h0, stopCmd = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0]  supplyLvl = 2'h0;
  logic        err;
  int          fail_count = 0, check_count = 0;
  logic [31:0] prdata;
  logic [15:0] resumeAddr;
  logic        pready, pslverr, belowWarn, belowRst, belowPor, ringOsc, stopReq;
  logic        monitorEn, regulatorEn, xtalEn, cpuReset, cpuHalt, portsFloat, irq;

  // Short crystal wait keeps the run brief
  smsms_top #(.XTAL_SETTLE_CYC(20)) u_smsms_top (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .belowWarnAsync(belowWarn), .belowRstAsync(belowRst),
    .belowPorAsync(belowPor), .extResetPin_b, .extIrqAsync, .ringOsc, .watchdogRst, .stopReq,
    .monitorEn, .regulatorEn, .xtalEn, .cpuReset, .cpuHalt, .portsFloat, .resumeAddr, .irq);
  smsms_partner u_smsms_partner (.sys_clk, .supplyLvl, .stopCmd, .belowWarn, .belowRst, .belowPor,
    .ringOsc, .stopReq);

  // 20 MHz clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task chk(input logic [31:0] e, input logic [31:0] a);
    check_count++;
    if (a !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk

  task chkB(input logic e, input logic a);
    chk({31'h0, e}, {31'h0, a});
  endtask : chkB

  // Request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1)
      @(posedge sys_clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(e, rd & m);
  endtask : rdChk

  // Bounded wait on halt (0) or reset (1), then compare
  task waitLvl(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (((s == 0) ? cpuHalt : cpuReset) !== v && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chkB(v, (s == 0) ? cpuHalt : cpuReset);
  endtask : waitLvl

  task hold(input logic [1:0] l, input int n);
    supplyLvl <= l;
    repeat (n) @(posedge sys_clk);
  endtask : hold

  task stop;
    @(posedge sys_clk);
    stopCmd <= 1'h1;
    @(posedge sys_clk);
    stopCmd <= 1'h0;
    waitLvl(0, 1'h1, 10);
  endtask : stop

  task results;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Hang guard, well past the longest path
  initial
  begin
    #3000000;
    fail_count++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    chkB(1'h1, cpuReset & portsFloat & ~monitorEn & ~cpuHalt & ~irq);
    rst_b <= 1'h1;
    waitLvl(1, 1'h0, 200);
    chkB(1'h1, monitorEn & ~portsFloat);
    for (int i = 0; i < 8; i++)
    begin
      if (ROWS[i].wr)
        apb(1'h1, ROWS[i].a, ROWS[i].d);
      apb(1'h0, ROWS[i].a, 32'h0);
      chk(ROWS[i].e, rd);
      chkB(ROWS[i].er, err);
    end
    hold(2'h1, 100);
    hold(2'h0, 300);
    rdChk(ADDR_STATUS, 32'hF, 32'h0);
    hold(2'h1, 260);
    hold(2'h0, 5);
    chkB(1'h0, irq | cpuReset);
    apb(1'h1, ADDR_MASK, 32'h1);
    @(posedge sys_clk);
    chkB(1'h1, irq);
    rdChk(ADDR_STATUS, 32'hF, 32'h1);
    @(posedge sys_clk);
    chkB(1'h0, irq);
    apb(1'h1, ADDR_MASK, 32'h0);
    apb(1'h1, ADDR_WAKE, 32'h2);
    stop();
    chkB(1'h0, monitorEn | regulatorEn | xtalEn);
    repeat (2400) @(posedge sys_clk);
    chkB(1'h1, cpuHalt);
    waitLvl(0, 1'h0, 3000);
    rdChk(ADDR_STATUS, 32'hF, 32'h2);
    apb(1'h1, ADDR_WAKE, 32'h0);
    stop();
    hold(2'h2, 300);
    chkB(1'h0, cpuReset);
    hold(2'h1, 10);
    extIrqAsync <= 1'h1;
    hold(2'h1, 5);
    extIrqAsync <= 1'h0;
    waitLvl(0, 1'h0, 100);
    hold(2'h0, 5);
    rdChk(ADDR_STATUS, 32'h1, 32'h1);
    apb(1'h1, ADDR_CTRL, 32'h0);
    stop();
    chkB(1'h1, monitorEn & ~xtalEn);
    hold(2'h1, 1);
    waitLvl(0, 1'h0, 300);
    hold(2'h0, 5);
    rdChk(ADDR_STATUS, 32'h1, 32'h1);
    hold(2'h2, 1);
    waitLvl(1, 1'h1, 300);
    chkB(1'h0, regulatorEn | xtalEn);
    hold(2'h0, 2400);
    chkB(1'h1, cpuReset);
    waitLvl(1, 1'h0, 12000);
    chk(32'h8000, {16'h0, resumeAddr});
    rdChk(ADDR_STATUS, 32'h4, 32'h4);
    // Watchdog first, then the reset pin
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      watchdogRst   <= (i == 0);
      extResetPin_b <= (i == 0);
      repeat (5) @(posedge sys_clk);
      chkB(1'h1, cpuReset & monitorEn & regulatorEn & xtalEn);
      watchdogRst   <= 1'h0;
      extResetPin_b <= 1'h1;
      waitLvl(1, 1'h0, 19);
    end
    chk(32'h0, {16'h0, resumeAddr});
    apb(1'h1, ADDR_CTRL, 32'h1);
    stop();
    hold(2'h3, 1);
    waitLvl(1, 1'h1, 10);
    chkB(1'h1, portsFloat);
    hold(2'h0, 1);
    waitLvl(1, 1'h0, 200);
    rdChk(ADDR_STATUS, 32'h8, 32'h8);
    // Mid-run reset with the supply dead: no early boot, no false entry
    rst_b <= 1'h0;
    hold(2'h3, 6);
    chkB(1'h1, cpuReset & portsFloat & ~regulatorEn & ~irq);
    rst_b <= 1'h1;
    hold(2'h3, 10);
    chkB(1'h1, cpuReset & ~regulatorEn);
    hold(2'h0, 1);
    waitLvl(1, 1'h0, 200);
    rdChk(ADDR_STATUS, 32'hF, 32'h0);
    // Fail level found on stop exit with the monitor off
    stop();
    hold(2'h2, 300);
    extIrqAsync <= 1'h1;
    hold(2'h2, 5);
    extIrqAsync <= 1'h0;
    waitLvl(1, 1'h1, 100);
    hold(2'h0, 1);
    waitLvl(1, 1'h0, 12000);
    chk(32'h8000, {16'h0, resumeAddr});
    rdChk(ADDR_STATUS, 32'h4, 32'h4);
    results();
  end
endmodule : smsms_top_test
